// ==== hdl/scmc_map.vh ====
// scmc_map.vh: register offsets, field positions, reset values and timing counts
// for the system clock and power-mode control block; assumes an APB slave with 8-bit paddr.
// Function
// R01: selector 000-110 divide fast by 1-64, 111 slow
// R02: fast mode clocks cpu from divided fast clock
// R03: selector 111 enters slow mode on slow clock
// R04: slow switch completes only once slow oscillator stable
// R05: fast clock in slow mode follows enable bit
// R06: fast keep-alive bit decides fast oscillator in halt
// R07: slow keep-alive bit decides slow oscillator in halt; code also runs it in sleep while wdt_enable is high
// R08: halt with both bits zero enters sleep
// R09: sleep keeps slow rc clock only with watchdog
// R10: halt fast 0 slow 1 enters idle slow only
// R11: halt both bits one enters idle both clocks
// R12: halt fast 1 slow 0 enters idle fast only
// R13: enabling fast oscillator clears then sets stable flag
// R14: fast oscillator enable bit resets to one
// R15: clock switch completes within bounded switch delay
// R16: unimplemented bits read zero, selector bits reset zero
// R17: halt sets power-down, clears timeout and watchdog counter
// R18: software polls stable flag after restarting fast oscillator
// R19: clock source switched glitch-free on safe edges
`ifndef SCMC_MAP_VH
`define SCMC_MAP_VH

`define SCMC_ADDR_SYSCLK_CTRL 8'h00
`define SCMC_ADDR_FAST_OSC_CTRL 8'h04
`define SCMC_ADDR_IRQ_STATUS 8'h08
`define SCMC_ADDR_IRQ_MASK 8'h0c
`define SCMC_ADDR_POWER_STATUS 8'h10

`define SCMC_SEL_MSB 7
`define SCMC_SEL_LSB 5
`define SCMC_FAST_KEEP_BIT 1
`define SCMC_SLOW_KEEP_BIT 0
`define SCMC_STABLE_BIT 1
`define SCMC_FAST_EN_BIT 0
`define SCMC_SEL_SLOW 3'h7

`define SCMC_SEL_RESET 3'h0
`define SCMC_KEEP_RESET 1'b0
`define SCMC_FAST_EN_RESET 1'b1
`define SCMC_MASK_RESET 3'h0

`define SCMC_IRQ_STABLE_BIT 0
`define SCMC_IRQ_SWITCH_BIT 1
`define SCMC_IRQ_HALT_BIT 2

`define SCMC_PD_BIT 0
`define SCMC_TO_BIT 1

`define SCMC_SWITCH_HOLD 3'h4

`endif

// ==== hdl/scmc_sync.v ====
// scmc_sync.v: two-flop synchroniser for levels arriving from the oscillators.
// assumes each bit is a slow level or a pulse wider than two pclk periods.
`timescale 1ns/10ps
module scmc_sync #(
	parameter WIDTH = 1
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // scmc_sync

// ==== hdl/scmc_div.v ====
// scmc_div.v: binary prescaler of the fast clock, one enable per ratio 1..64.
// assumes run is low whenever the fast oscillator is stopped or unstable.
`timescale 1ns/10ps
module scmc_div #(
	parameter STAGES = 6
) (
	input wire pclk,
	input wire presetn,
	input wire run,
	output wire [STAGES:0] tick
);
	reg [STAGES-1:0] cnt_ff;
	wire [STAGES-1:0] nxt_cnt;

	assign nxt_cnt = run ? cnt_ff + {{(STAGES-1){1'b0}}, 1'b1} : cnt_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= {STAGES{1'b0}};
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign tick[0] = run;
	genvar i;
	generate
		for (i = 1; i <= STAGES; i = i + 1) begin : g_ratio
			// ratio 2^i ticks when the low i counter bits are all ones
			assign tick[i] = run & (&cnt_ff[i-1:0]); // see R01
		end
	endgenerate
endmodule // scmc_div

// ==== hdl/scmc_top.v ====
// scmc_top.v: system clock selection, glitch-free switching and halt power modes.
// assumes oscillator status and the slow rc clock arrive as pins, cpu signals on pclk.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "scmc_map.vh"
module scmc_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire halt_req,
	input wire wake_req,
	input wire wdt_enable,
	input wire wdt_clear_cmd,
	input wire fast_osc_ready,
	input wire slow_osc_ready,
	input wire slow_rc_oscillator,
	output wire fast_osc_run,
	output wire slow_osc_run,
	output wire cpu_clk_en,
	output wire system_clock_en,
	output wire fast_clock_en,
	output wire [6:0] fast_periph_en,
	output wire slow_clock_en,
	output wire slow_rc_clock_en,
	output wire power_down_flag,
	output wire watchdog_timeout_clr,
	output wire watchdog_counter_clr,
	output wire cpu_halted,
	output wire irq
);
	localparam [4:0] ST_RUN = 5'h01;
	localparam [4:0] ST_SLEEP = 5'h02;
	localparam [4:0] ST_IDLE_SLOW = 5'h04;
	localparam [4:0] ST_IDLE_BOTH = 5'h08;
	localparam [4:0] ST_IDLE_FAST = 5'h10;

	reg [2:0] sel_ff;
	reg fast_keep_ff;
	reg slow_keep_ff;
	reg fast_en_ff;
	reg stable_ff;
	reg [2:0] irq_stat_ff;
	reg [2:0] irq_mask_ff;
	reg pd_ff;
	reg [4:0] mode_ff;
	reg [4:0] nxt_mode;
	reg halt_evt_ff;
	reg slow_prev_ff;
	reg fast_run_prev_ff;
	reg [2:0] act_sel_ff;
	reg engaged_ff;
	reg busy_ff;
	reg gap_ff;
	reg [2:0] hold_ff;
	reg sw_done_ff;

	wire fast_ready_s;
	wire slow_ready_s;
	wire slow_level_s;
	wire slow_tick;
	wire fast_run_int;
	wire [6:0] div_tick;
	wire run_mode;
	wire wr_en;
	wire rd_en;
	wire stable_rise;
	wire cur_tick;
	wire tgt_tick;
	wire tgt_stable;
	wire sys_on_in_halt;

	scmc_sync #(
		.WIDTH(3)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({fast_osc_ready, slow_osc_ready, slow_rc_oscillator}),
		.sync_out({fast_ready_s, slow_ready_s, slow_level_s})
	);

	// edge detect reads the second synchroniser stage only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_prev_ff <= 1'b0;
		end else begin
			slow_prev_ff <= slow_level_s;
		end
	end
	assign slow_tick = slow_level_s & ~slow_prev_ff & slow_osc_run & slow_ready_s;

	assign run_mode = mode_ff[0];

	// fast oscillator: in run mode kept for fast mode or any switch touching it, else by enable bit; in halt only idle both and idle fast keep it
	assign fast_osc_run = run_mode ?
		(fast_en_ff | (sel_ff != `SCMC_SEL_SLOW) | (act_sel_ff != `SCMC_SEL_SLOW)) :
		(mode_ff[3] | mode_ff[4]); // see R05 R06 R08 R10 R11 R12
	// slow oscillator runs in run modes, idle modes with keep bit, sleep only for watchdog
	assign slow_osc_run = run_mode | mode_ff[2] | mode_ff[3] |
		(mode_ff[1] & wdt_enable); // see R07 R09

	assign fast_run_int = fast_osc_run & stable_ff;

	scmc_div #(
		.STAGES(6)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(fast_run_int),
		.tick(div_tick)
	);

	assign fast_clock_en = fast_run_int;
	assign fast_periph_en = div_tick; // see R05
	assign slow_rc_clock_en = slow_tick; // see R09
	// peripheral slow clock stops in sleep and idle fast only
	assign slow_clock_en = slow_tick & ~mode_ff[1] & ~mode_ff[4]; // see R08 R12

	// source tick of a selector code
	assign cur_tick = (act_sel_ff == `SCMC_SEL_SLOW) ? slow_tick : div_tick[act_sel_ff]; // see R01
	assign tgt_tick = (sel_ff == `SCMC_SEL_SLOW) ? slow_tick : div_tick[sel_ff]; // see R01
	// slow target requires a stable slow oscillator before engaging
	assign tgt_stable = (sel_ff == `SCMC_SEL_SLOW) ? slow_ready_s : stable_ff; // see R04

	// glitch-free switch: hold old source a few of its ticks, drop it, engage on a target tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_sel_ff <= `SCMC_SEL_RESET;
			engaged_ff <= 1'b1;
			busy_ff <= 1'b0;
			gap_ff <= 1'b0;
			hold_ff <= 3'h0;
			sw_done_ff <= 1'b0;
		end else begin
			sw_done_ff <= 1'b0;
			if (!busy_ff) begin
				if (sel_ff != act_sel_ff) begin
					busy_ff <= 1'b1;
					gap_ff <= 1'b0;
					hold_ff <= 3'h0;
				end
			end else if (!gap_ff) begin
				// bounded hold on the current clock before release
				if (hold_ff == `SCMC_SWITCH_HOLD) begin
					gap_ff <= 1'b1;
					engaged_ff <= 1'b0; // see R15 R19
				end else if (cur_tick) begin
					hold_ff <= hold_ff + 3'h1; // see R15
				end
			end else if (tgt_stable && tgt_tick) begin
				act_sel_ff <= sel_ff; // see R03 R04 R19
				engaged_ff <= 1'b1;
				busy_ff <= 1'b0;
				gap_ff <= 1'b0;
				sw_done_ff <= 1'b1;
			end
		end
	end

	// system clock in halt modes follows the idle table
	assign sys_on_in_halt = mode_ff[3] |
		(mode_ff[2] & (act_sel_ff == `SCMC_SEL_SLOW)) |
		(mode_ff[4] & (act_sel_ff != `SCMC_SEL_SLOW)); // see R10 R11 R12
	assign system_clock_en = engaged_ff & cur_tick & (run_mode | sys_on_in_halt); // see R02 R03
	assign cpu_clk_en = engaged_ff & cur_tick & run_mode; // see R02 R03 R08
	assign cpu_halted = ~run_mode;

	// power mode state machine
	always @* begin
		nxt_mode = mode_ff;
		case (mode_ff)
			ST_RUN: begin
				if (halt_req) begin
					case ({fast_keep_ff, slow_keep_ff})
						2'b00: nxt_mode = ST_SLEEP; // see R08
						2'b01: nxt_mode = ST_IDLE_SLOW; // see R10
						2'b11: nxt_mode = ST_IDLE_BOTH; // see R11
						default: nxt_mode = ST_IDLE_FAST; // see R12
					endcase
				end
			end
			ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST: begin
				if (wake_req) begin
					nxt_mode = ST_RUN;
				end
			end
			default: nxt_mode = ST_RUN;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= ST_RUN;
			halt_evt_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			halt_evt_ff <= run_mode & halt_req;
		end
	end

	// power-down flag: halt sets, clear-watchdog command clears, set wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_ff <= 1'b0;
		end else if (halt_evt_ff) begin
			pd_ff <= 1'b1; // see R17
		end else if (wdt_clear_cmd) begin
			pd_ff <= 1'b0;
		end
	end
	assign power_down_flag = pd_ff;
	assign watchdog_timeout_clr = halt_evt_ff; // see R17
	assign watchdog_counter_clr = halt_evt_ff; // see R17

	// apb slave, zero wait states
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff <= `SCMC_SEL_RESET; // see R16
			fast_keep_ff <= `SCMC_KEEP_RESET; // see R16
			slow_keep_ff <= `SCMC_KEEP_RESET; // see R16
			fast_en_ff <= `SCMC_FAST_EN_RESET; // see R14
			irq_mask_ff <= `SCMC_MASK_RESET;
		end else if (wr_en) begin
			if (paddr == `SCMC_ADDR_SYSCLK_CTRL) begin
				sel_ff <= pwdata[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
				fast_keep_ff <= pwdata[`SCMC_FAST_KEEP_BIT];
				slow_keep_ff <= pwdata[`SCMC_SLOW_KEEP_BIT];
			end else if (paddr == `SCMC_ADDR_FAST_OSC_CTRL) begin
				fast_en_ff <= pwdata[`SCMC_FAST_EN_BIT];
			end else if (paddr == `SCMC_ADDR_IRQ_MASK) begin
				irq_mask_ff <= pwdata[2:0];
			end
		end
	end

	// stable flag drops whenever the oscillator (re)starts, sets on synced ready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_run_prev_ff <= 1'b0;
			stable_ff <= 1'b0;
		end else begin
			fast_run_prev_ff <= fast_osc_run;
			if (!fast_osc_run || !fast_run_prev_ff) begin
				stable_ff <= 1'b0; // see R13
			end else if (fast_ready_s) begin
				stable_ff <= 1'b1; // see R13 R18
			end
		end
	end
	assign stable_rise = fast_osc_run & fast_run_prev_ff & fast_ready_s & ~stable_ff;

	// sticky events, write one to clear; a new event in the clear cycle wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= 3'h0;
		end else begin
			if (wr_en && paddr == `SCMC_ADDR_IRQ_STATUS) begin
				irq_stat_ff <= (irq_stat_ff & ~pwdata[2:0]) |
					{halt_evt_ff, sw_done_ff, stable_rise};
			end else begin
				irq_stat_ff <= irq_stat_ff | {halt_evt_ff, sw_done_ff, stable_rise};
			end
		end
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// read data is registered in the setup cycle so it is held through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata <= 32'h00000000; // see R16
			if (paddr == `SCMC_ADDR_SYSCLK_CTRL) begin
				if (rd_en) begin
					prdata <= {24'h000000, sel_ff, 3'h0, fast_keep_ff, slow_keep_ff}; // see R16
				end
			end else if (paddr == `SCMC_ADDR_FAST_OSC_CTRL) begin
				if (rd_en) begin
					prdata <= {30'h00000000, stable_ff, fast_en_ff}; // see R13 R16
				end
			end else if (paddr == `SCMC_ADDR_IRQ_STATUS) begin
				if (rd_en) begin
					prdata <= {29'h00000000, irq_stat_ff};
				end
			end else if (paddr == `SCMC_ADDR_IRQ_MASK) begin
				if (rd_en) begin
					prdata <= {29'h00000000, irq_mask_ff};
				end
			end else if (paddr == `SCMC_ADDR_POWER_STATUS) begin
				if (rd_en) begin
					prdata <= {30'h00000000, 1'b0, pd_ff};
				end
			end else begin
				// unmapped: error answer, reads zero, writes dropped
				pslverr <= 1'b1;
			end
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end
endmodule // scmc_top

// ==== bench/scmc_top_monitor.sv ====
// scmc_top_monitor.sv: port assertions for the clock and power-mode block.
// assumes software writes the clock control register over apb.
`timescale 1ns/10ps
module scmc_monitor (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic halt_req,
	input logic wdt_enable,
	input logic cpu_halted,
	input logic system_clock_en,
	input logic fast_osc_run,
	input logic slow_osc_run,
	input logic slow_clock_en,
	input logic slow_rc_clock_en,
	input logic watchdog_counter_clr,
	input logic watchdog_timeout_clr,
	input logic fast_clock_en,
	input logic power_down_flag
);
	logic [2:0] sel_ff;
	logic [1:0] keep_ff;
	logic go;
	assign go = halt_req && !cpu_halted;
	// written value only, so a halt during a pending switch is judged on the new selector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff <= 3'h0;
			keep_ff <= 2'h0;
		end else if (psel && penable && pwrite && paddr == 8'h00) begin
			sel_ff <= pwdata[7:5];
			keep_ff <= pwdata[1:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_halt_taken: assert property (go |=> cpu_halted)
		else $error("halt not taken");
	chk_halt_clears: assert property (
		go |=> watchdog_counter_clr ##1 power_down_flag)
		else $error("halt side effects");
	chk_fast_keep: assert property (cpu_halted |-> fast_osc_run == keep_ff[1])
		else $error("fast osc in halt");
	chk_slow_keep: assert property (cpu_halted && keep_ff[0] |-> slow_osc_run)
		else $error("slow osc in halt");
	chk_slow_gated: assert property (cpu_halted && !keep_ff[0] |-> !slow_clock_en)
		else $error("slow clock in halt");
	// the synchroniser may still hold one edge just after entry
	chk_rc_sleep: assert property (
		cpu_halted && $past(cpu_halted, 4) && keep_ff == 2'h0 && !wdt_enable
		|-> !slow_rc_clock_en)
		else $error("rc clock in sleep");
	chk_sys_off: assert property (
		cpu_halted && (keep_ff == 2'h0 || keep_ff[0] != keep_ff[1] &&
		(sel_ff == 3'h7) == keep_ff[1]) |-> !system_clock_en)
		else $error("system clock in halt");
	chk_sys_both: assert property (
		cpu_halted && keep_ff == 2'h3 && sel_ff == 3'h0 |-> system_clock_en)
		else $error("system clock stopped");
	chk_timeout_clr: assert property (go |=> watchdog_timeout_clr)
		else $error("timeout clear missing");
	chk_fast_gated: assert property (fast_clock_en |-> fast_osc_run)
		else $error("fast clock without oscillator");
endmodule // scmc_monitor
bind scmc_top scmc_monitor u_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.halt_req(halt_req), .wdt_enable(wdt_enable), .cpu_halted(cpu_halted),
	.system_clock_en(system_clock_en), .fast_osc_run(fast_osc_run),
	.slow_osc_run(slow_osc_run), .slow_clock_en(slow_clock_en),
	.slow_rc_clock_en(slow_rc_clock_en), .watchdog_counter_clr(watchdog_counter_clr),
	.watchdog_timeout_clr(watchdog_timeout_clr), .fast_clock_en(fast_clock_en),
	.power_down_flag(power_down_flag));

// ==== bench/scmc_top_test.sv ====
// scmc_top_test.sv: self-checking bench for the clock and power-mode block.
// assumes zero-wait apb; oscillators are modelled as ready followers.
`timescale 1ns/10ps
`include "scmc_map.vh"
module scmc_top_test;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic wdt_enable = 1'h0, hold = 1'h0, fast_osc_ready = 1'h0, slow_osc_ready = 1'h0;
	logic slow_rc_oscillator = 1'h0, pready, pslverr, fast_osc_run, slow_osc_run, cpu_halted, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] cmd = 3'h0, sdiv = 3'h0;
	logic [6:0] fast_periph_en;
	wire [3:0] probe;
	int bad_count = 0, compares = 0;
	always #4 pclk = ~pclk;
	// ready trails the enable; the slow clock stands still while its oscillator is off
	always @(posedge pclk) begin
		fast_osc_ready <= fast_osc_run;
		slow_osc_ready <= slow_osc_run && !hold;
		if (slow_osc_run) begin
			sdiv <= sdiv + 3'h1;
			slow_rc_oscillator <= slow_rc_oscillator ^ (sdiv == 3'h7);
		end
	end
	scmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_req(cmd[0]), .wake_req(cmd[1]), .wdt_enable(wdt_enable),
		.wdt_clear_cmd(cmd[2]), .fast_osc_ready(fast_osc_ready),
		.slow_osc_ready(slow_osc_ready), .slow_rc_oscillator(slow_rc_oscillator),
		.fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run), .cpu_clk_en(probe[0]),
		.system_clock_en(probe[1]), .fast_clock_en(), .fast_periph_en(fast_periph_en),
		.slow_clock_en(probe[2]), .slow_rc_clock_en(probe[3]), .power_down_flag(),
		.watchdog_timeout_clr(), .watchdog_counter_clr(), .cpu_halted(cpu_halted), .irq(irq));
	task results;
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 9);
		if (n == 9) begin
			chk("pready", 1, pready);
			results;
		end
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'h0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task cnt(input int b, input int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(posedge pclk);
			#1;
			n += probe[b];
		end
	endtask
	task pulse(input int b);
		@(posedge pclk);
		cmd[b] <= 1'h1;
		@(posedge pclk);
		cmd[b] <= 1'h0;
	endtask
	// a timeout here counts as a failed compare in this task and ends the run
	task poll(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin
			apb(1'h0, a, 32'h0);
			n++;
		end while (rd[b] !== 1'h1 && n < 150);
		if (rd[b] !== 1'h1) begin
			chk("poll timeout", 1, rd[b]);
			results;
		end
	endtask
	task wait_done;
		poll(`SCMC_ADDR_IRQ_STATUS, 1);
		chk("switch done", 1, rd[1]);
		chk("irq set", 1, irq);
		apb(1'h1, `SCMC_ADDR_IRQ_STATUS, 32'h2);
		#1;
		chk("irq clear", 0, irq);
	endtask
	task t_regs;
		rchk(`SCMC_ADDR_SYSCLK_CTRL, 32'h0, "clock control");
		repeat (8) @(posedge pclk);
		rchk(`SCMC_ADDR_FAST_OSC_CTRL, 32'h3, "fast control");
		apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, 32'h1f);
		rchk(`SCMC_ADDR_SYSCLK_CTRL, 32'h3, "unused bits");
		apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, 32'h0);
		rchk(8'h20, 32'h0, "unmapped");
		chk("slverr", 1, pslverr);
		apb(1'h1, `SCMC_ADDR_IRQ_MASK, 32'h2);
	endtask
	task t_divide;
		int n;
		for (int k = 1; k <= 7; k++) begin
			apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, (k % 7) << 5);
			wait_done;
			cnt(0, 128, n);
			chk("cpu ticks", 128 >> (k % 7), n);
		end
	endtask
	task t_slow;
		int n;
		hold <= 1'h1;
		apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, 32'he0);
		repeat (100) @(posedge pclk);
		// bit0 stays set from the stable rise after reset; it is never cleared
		rchk(`SCMC_ADDR_IRQ_STATUS, 32'h1, "held");
		chk("switch held", 0, rd[1]);
		hold <= 1'h0;
		wait_done;
		cnt(0, 160, n);
		chk("slow ticks", 10, n);
		apb(1'h1, `SCMC_ADDR_FAST_OSC_CTRL, 32'h0);
		repeat (4) @(posedge pclk);
		#1;
		chk("fast off", 0, {fast_osc_run, fast_periph_en});
		apb(1'h1, `SCMC_ADDR_FAST_OSC_CTRL, 32'h1);
		rchk(`SCMC_ADDR_FAST_OSC_CTRL, 32'h1, "stable clear");
		poll(`SCMC_ADDR_FAST_OSC_CTRL, 1);
		chk("stable set", 32'h3, rd);
		#1;
		chk("fast on", 1, fast_periph_en[0]);
		apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, 32'he2);
		pulse(0);
		cnt(1, 64, n);
		chk("idle sys", 0, n);
		pulse(1);
		apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, 32'h0);
		wait_done;
	endtask
	// last pass is sleep with the watchdog on
	task t_halt;
		int n;
		for (int i = 0; i < 5; i++) begin
			apb(1'h1, `SCMC_ADDR_SYSCLK_CTRL, i & 3);
			wdt_enable <= (i == 4);
			pulse(0);
			cnt(1, 64, n);
			chk("halt sys", i[1] ? 64 : 0, n);
			cnt(2, 64, n);
			chk("halt slow", i[0] ? 4 : 0, n);
			chk("halt fast", i[1], fast_osc_run);
			chk("masked irq", 0, irq);
			if (i % 4 == 0) begin
				cnt(3, 64, n);
				chk("sleep rc", i == 4 ? 4 : 0, n);
			end
			rchk(`SCMC_ADDR_POWER_STATUS, 32'h1, "pd set");
			pulse(1);
			#1;
			chk("woken", 0, cpu_halted);
			pulse(2);
			rchk(`SCMC_ADDR_POWER_STATUS, 32'h0, "pd clear");
		end
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_divide;
		t_slow;
		t_halt;
		results;
	end
endmodule // scmc_top_test
